// File: core/blia_chan.sv
// Per-channel summary latch with block-level gating.
`timescale 1ns/1ns
module blia_chan
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic blk_en_in,
  input  wire logic src_req_in,
  input  wire logic src_read_in,
  output logic      summary_out,
  output logic      set_pulse_out
);

  logic summary_r;
  logic summary_nxt;
  logic set_now;

  // A cause only counts when the block enable is high as well.
  assign set_now = blk_en_in & src_req_in;

  // Set wins over the clearing read; a disabled channel holds nothing pending.
  assign summary_nxt = !blk_en_in ? 1'b0 :
                       set_now    ? 1'b1 :
                       src_read_in ? 1'b0 : summary_r;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      summary_r <= 1'b0;
    else
      summary_r <= summary_nxt;
  end

  assign summary_out   = summary_r;
  assign set_pulse_out = summary_nxt & ~summary_r;

endmodule

// File: core/blia_top.sv
// Block interrupt aggregator: APB register slave, per-channel gating and summary.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns

module blia_top
(
  input  wire logic                          clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [blia_pkg::ADDR_W-1:0]   paddr_in,
  input  wire logic [blia_pkg::DATA_W-1:0]   pwdata_in,
  input  wire logic [3:0]                    pstrb_in,
  output logic      [blia_pkg::DATA_W-1:0]   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  input  wire logic [blia_pkg::NUM_CH-1:0]   src_req_in,
  input  wire logic [blia_pkg::NUM_CH-1:0]   src_stat_read_in,
  output logic                               irq_out,
  output logic                               evt_irq_out
);

  // ****************************************************************
  // Bus request capture
  // ****************************************************************
  blia_pkg::blia_apb_req_s req;
  blia_pkg::blia_src_s     src;

  assign req.sel    = psel_in;
  assign req.enable = penable_in;
  assign req.write  = pwrite_in;
  assign req.addr   = paddr_in;
  assign req.wdata  = pwdata_in;
  assign req.strb   = pstrb_in;
  assign src.req    = src_req_in;
  assign src.rd     = src_stat_read_in;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [blia_pkg::IDX_W-1:0] idx;
  logic                       aligned;
  logic                       hit_en;
  logic                       hit_stat;
  logic                       hit_evt;
  logic                       hit_mask;
  logic                       mapped;
  logic                       bad_write;
  logic                       setup_ph;
  logic                       access_ph;
  logic                       wr_ok;
  logic                       lane0;

  assign idx       = req.addr[blia_pkg::ADDR_W-1:2];
  assign aligned   = (req.addr[1:0] == 2'h0);
  assign hit_en    = aligned & (idx == blia_pkg::IDX_BLK_EN);
  assign hit_stat  = aligned & (idx == blia_pkg::IDX_BLK_STAT);
  assign hit_evt   = aligned & (idx == blia_pkg::IDX_EVT_STAT);
  assign hit_mask  = aligned & (idx == blia_pkg::IDX_EVT_MASK);
  assign mapped    = hit_en | hit_stat | hit_evt | hit_mask;
  // The summary register is read-only; a write there is answered with an error.
  assign bad_write = req.write & hit_stat;
  assign setup_ph  = req.sel & ~req.enable;
  assign access_ph = req.sel & req.enable;
  assign wr_ok     = access_ph & req.write & mapped & ~bad_write;
  assign lane0     = req.strb[0];

  // Zero wait states: every access completes in its first access cycle.
  assign pready_out  = 1'b1;
  assign pslverr_out = access_ph & (~mapped | bad_write);

  // ****************************************************************
  // Software-written registers
  // ****************************************************************
  logic [blia_pkg::NUM_CH-1:0] blk_en_r;
  logic [blia_pkg::NUM_CH-1:0] blk_en_nxt;
  logic [blia_pkg::NUM_CH-1:0] evt_mask_r;
  logic [blia_pkg::NUM_CH-1:0] evt_mask_nxt;
  logic                        en_we;
  logic                        mask_we;
  logic                        evt_w1c;
  logic [blia_pkg::NUM_CH-1:0] wr_bits;

  assign wr_bits      = req.wdata[blia_pkg::NUM_CH-1:0];
  assign en_we        = wr_ok & hit_en & lane0;
  assign mask_we      = wr_ok & hit_mask & lane0;
  assign evt_w1c      = wr_ok & hit_evt & lane0;
  // Only the three channel bits are kept; bits above them read as zero.
  assign blk_en_nxt   = en_we ? wr_bits : blk_en_r;
  assign evt_mask_nxt = mask_we ? wr_bits : evt_mask_r;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      blk_en_r   <= blia_pkg::BLK_EN_RST;
      evt_mask_r <= blia_pkg::EVT_MASK_RST;
    end
    else
    begin
      blk_en_r   <= blk_en_nxt;
      evt_mask_r <= evt_mask_nxt;
    end
  end

  // ****************************************************************
  // Channel summaries
  // ****************************************************************
  logic [blia_pkg::NUM_CH-1:0] summary;
  logic [blia_pkg::NUM_CH-1:0] set_pulse;

  genvar ch;
  generate
    for (ch = 0; ch < blia_pkg::NUM_CH; ch = ch + 1)
    begin : g_chan
      // Each channel sees only its own enable bit and source lines.
      blia_chan u_chan
      (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .blk_en_in     (blk_en_r[ch]),
        .src_req_in    (src.req[ch]),
        .src_read_in   (src.rd[ch]),
        .summary_out   (summary[ch]),
        .set_pulse_out (set_pulse[ch])
      );
    end
  endgenerate

  // ****************************************************************
  // Sticky event status
  // ****************************************************************
  logic [blia_pkg::NUM_CH-1:0] evt_stat_r;
  logic [blia_pkg::NUM_CH-1:0] evt_stat_nxt;
  logic [blia_pkg::NUM_CH-1:0] evt_clr;

  assign evt_clr      = evt_w1c ? wr_bits : {blia_pkg::NUM_CH{1'b0}};
  // A new event in the clearing cycle survives the clear.
  assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | set_pulse;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      evt_stat_r <= blia_pkg::EVT_STAT_RST;
    else
      evt_stat_r <= evt_stat_nxt;
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [blia_pkg::NUM_CH-1:0] rd_sel;
  logic [blia_pkg::DATA_W-1:0] prdata_r;
  logic [blia_pkg::DATA_W-1:0] prdata_nxt;
  logic                        rd_cap;

  // Read data is captured in the setup cycle so the access cycle drives a flop.
  assign rd_cap = setup_ph & ~req.write;
  assign rd_sel = hit_en   ? blk_en_r   :
                  hit_stat ? summary    :
                  hit_evt  ? evt_stat_r :
                  hit_mask ? evt_mask_r : {blia_pkg::NUM_CH{1'b0}};
  assign prdata_nxt = rd_cap ? {{(blia_pkg::DATA_W-blia_pkg::NUM_CH){1'b0}}, rd_sel} :
                      prdata_r;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      prdata_r <= blia_pkg::RDATA_RST;
    else
      prdata_r <= prdata_nxt;
  end

  assign prdata_out = prdata_r;

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  logic irq_r;
  logic evt_irq_r;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      irq_r     <= 1'b0;
      evt_irq_r <= 1'b0;
    end
    else
    begin
      irq_r     <= |summary_gate(summary, blk_en_r);
      evt_irq_r <= |(evt_stat_nxt & evt_mask_nxt);
    end
  end

  function automatic logic [blia_pkg::NUM_CH-1:0] summary_gate
  (
    input logic [blia_pkg::NUM_CH-1:0] s,
    input logic [blia_pkg::NUM_CH-1:0] e
  );
    summary_gate = s & e;
  endfunction

  // The summary request follows the enabled summary bits (summary & blk_en_r) one cycle later.
  assign irq_out     = irq_r;
  assign evt_irq_out = evt_irq_r;

endmodule

// File: inc/blia_pkg.sv
// Constants, field layouts and bus carrier types for the block interrupt aggregator.
package blia_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_CH     = 3;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned IDX_W      = 6;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_BLK_EN     = 6'h20;
  localparam logic [IDX_W-1:0] IDX_BLK_STAT   = 6'h21;
  localparam logic [IDX_W-1:0] IDX_EVT_STAT   = 6'h22;
  localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 6'h23;

  // Source-level status addresses that software reads to clear a summary bit.
  localparam logic [7:0] SRC_STAT_ADDR_CH0 = 8'h02;
  localparam logic [7:0] SRC_STAT_ADDR_CH1 = 8'h0a;
  localparam logic [7:0] SRC_STAT_ADDR_CH2 = 8'h12;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CH0_BIT = 0;
  localparam int unsigned CH1_BIT = 1;
  localparam int unsigned CH2_BIT = 2;
  localparam logic [NUM_CH-1:0] BLK_EN_RST   = 3'h0;
  localparam logic [NUM_CH-1:0] BLK_STAT_RST = 3'h0;
  localparam logic [NUM_CH-1:0] EVT_STAT_RST = 3'h0;
  localparam logic [NUM_CH-1:0] EVT_MASK_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST    = 32'h0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        strb;
  } blia_apb_req_s;

  typedef struct packed {
    logic [NUM_CH-1:0] req;
    logic [NUM_CH-1:0] rd;
  } blia_src_s;

endpackage

// File: test/blia_checker.sv
// Port-level assertions for the block interrupt aggregator.
`timescale 1ns/1ns
module blia_checker
(
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [2:0]  src_req_in,
  input wire logic [2:0]  src_stat_read_in,
  input wire logic        irq_out
);
  // ********
  // Enable shadow and helper terms
  // ********
  logic [2:0] en_r;
  logic       acc;
  logic       known;
  logic       set_any;
  logic       clr_any;
  assign acc = psel_in && penable_in;
  assign known = paddr_in inside {8'h80, 8'h84, 8'h88, 8'h8c};
  assign set_any = |(en_r & src_req_in);
  // A fall needs a clearing read or a write that turns an enabled channel off.
  assign clr_any = |src_stat_read_in ||
                   (acc && pwrite_in && paddr_in == 8'h80 && pstrb_in[0] &&
                    |(en_r & ~pwdata_in[2:0]));
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      en_r <= 3'h0;
    else if (acc && pwrite_in && paddr_in == 8'h80 && pstrb_in[0])
      en_r <= pwdata_in[2:0];
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ready_high_a: assert property (acc |-> pready_out) else $error("no ready");
  bad_addr_a: assert property (acc && !known |-> pslverr_out) else $error("no error");
  stat_ro_a: assert property (acc && pwrite_in && paddr_in == 8'h84 |-> pslverr_out)
    else $error("status write accepted");
  en_ok_a: assert property (acc && paddr_in == 8'h80 |-> !pslverr_out)
    else $error("enable access refused");
  rd_upper_a: assert property (acc && !pwrite_in |-> prdata_out[31:3] == 29'h0)
    else $error("upper read bits set");
  gate_off_a: assert property (en_r == 3'h0 && $past(en_r) == 3'h0 && $past(en_r, 2) == 3'h0
    |-> !irq_out) else $error("irq while disabled");
  req_rise_a: assert property ($rose(irq_out) |-> $past(set_any, 2))
    else $error("irq without cause");
  irq_hold_a: assert property ($fell(irq_out) |-> $past(clr_any, 2))
    else $error("irq dropped early");
  cover property ($rose(irq_out));
  cover property ($fell(irq_out));
  cover property (acc && pslverr_out);
endmodule

bind blia_top blia_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .src_req_in(src_req_in),
  .src_stat_read_in(src_stat_read_in), .irq_out(irq_out));

// File: test/blia_top_tb.sv
// Self-checking bench for the block interrupt aggregator.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module blia_top_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  pstrb_in = 4'hf;
  logic [2:0]  src_req_in = 3'h0;
  logic [2:0]  src_stat_read_in = 3'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic        evt_irq_out;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  en;
  logic [2:0]  rq;
  logic [2:0]  rp;
  logic [2:0]  sum;
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0;

  always #10 clk_in = ~clk_in;

  blia_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .src_req_in(src_req_in),
    .src_stat_read_in(src_stat_read_in), .irq_out(irq_out), .evt_irq_out(evt_irq_out));

  // ********
  // Tasks and expectations
  // ********
  task results;
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Request and read pulses last one cycle; the wait covers the irq register stage.
  task pulse(input logic [2:0] q, input logic [2:0] r);
    @(posedge clk_in);
    src_req_in <= q;
    src_stat_read_in <= r;
    @(posedge clk_in);
    src_req_in <= 3'h0;
    src_stat_read_in <= 3'h0;
    repeat (2) @(posedge clk_in);
    sum = ((sum & ~r) | q) & en;
  endtask

  always @(posedge clk_in)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      errors++;
      results();
    end
  end

  initial
  begin
    void'($urandom(87547));
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(0, 8'h80, 0); `CHK("en reset", 32'h0, rd)
    apb(0, 8'h84, 0); `CHK("stat reset", 32'h0, rd)
    apb(1, 8'h84, 32'hff); `CHK("stat write err", 1'b1, er)
    apb(0, 8'h91, 0); `CHK("unmapped err", 1'b1, er)
    sum = 3'h0;
    for (int i = 0; i < 24; i++)
    begin
      en = (i < 3) ? 3'h1 << i : 3'($urandom);
      rq = (i < 3) ? 3'h7 : 3'($urandom);
      rp = (i < 3) ? ~(3'h1 << i) : 3'($urandom);
      apb(1, 8'h80, 32'hffff_fff8 | 32'(en));
      apb(0, 8'h80, 0); `CHK("enable", {29'h0, en}, rd)
      pulse(rq, 3'h0);
      `CHK("irq", |sum, irq_out)
      apb(0, 8'h84, 0); `CHK("status", {29'h0, sum}, rd)
      pulse(3'h0, rp);
      apb(0, 8'h84, 0); `CHK("status hold", {29'h0, sum}, rd)
      pulse(3'h0, 3'h7);
      apb(0, 8'h84, 0); `CHK("status clear", 32'h0, rd)
    end
    en = 3'h4;
    apb(1, 8'h88, 32'h7);
    apb(1, 8'h8c, 32'h0);
    apb(1, 8'h80, 32'h4);
    pstrb_in <= 4'he;
    apb(1, 8'h80, 32'h3);
    pstrb_in <= 4'hf;
    apb(0, 8'h80, 0); `CHK("strobe off", 32'h4, rd)
    pulse(3'h7, 3'h0);
    apb(0, 8'h88, 0); `CHK("event", 32'h4, rd)
    `CHK("evt masked", 1'b0, evt_irq_out)
    apb(1, 8'h8c, 32'h7);
    @(posedge clk_in);
    `CHK("evt irq", 1'b1, evt_irq_out)
    apb(1, 8'h88, 32'h4);
    @(posedge clk_in);
    `CHK("evt cleared", 1'b0, evt_irq_out)
    apb(1, 8'h80, 32'h0);
    repeat (3) @(posedge clk_in);
    `CHK("irq disabled", 1'b0, irq_out)
    apb(0, 8'h84, 0); `CHK("stat disabled", 32'h0, rd)
    apb(1, 8'h80, 32'h7);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    apb(0, 8'h80, 0); `CHK("en mid reset", 32'h0, rd)
    results();
  end
endmodule
